// ==== include/oppo_pkg.sv ====
// Constants shared by the optical port and energy pulse output logic.
// Assumes a single 250 MHz clock and a classic Wishbone slave with 32-bit data.
package oppo_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int SAMPLE_PERIOD_PS = 397000000;
  // One sample period rounded down to whole clock cycles.
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_PS / CLK_PERIOD_PS;
  // The pacing interval is counted in ticks; the paced interval value is 81.
  localparam int PACING_INTERVAL  = 81;
  localparam int TICK_CYCLES      = SAMPLE_CYCLES / PACING_INTERVAL;
  // Carrier: sixteen steps per period, each step a fixed number of clocks.
  localparam int CARRIER_STEP_CYCLES = 411;
  localparam logic [3:0] CARRIER_LAST = 4'hF;
  localparam logic [4:0] CARRIER_HALF = 5'h08;
  localparam int TIMER_W          = 17;
  localparam int STEP_W           = 9;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [13:0] IDX_PULSE_CFG  = 14'h2004;
  localparam logic [13:0] IDX_TX_CFG     = 14'h2007;
  localparam logic [13:0] IDX_PORT_CFG   = 14'h2008;
  localparam logic [13:0] IDX_WIDTH_LIM  = 14'h2080;
  localparam logic [13:0] IDX_INTERVAL   = 14'h2081;
  localparam logic [13:0] IDX_GENERAL_IO = 14'h2090;
  localparam logic [13:0] IDX_STATUS     = 14'h2091;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int POS_PULSE_INV  = 6;
  localparam int POS_TX_SRC     = 6;
  localparam int POS_DUTY       = 0;
  localparam int POS_TX_INV     = 0;
  localparam int POS_TX_MOD     = 1;
  localparam int POS_RX_INV     = 4;
  localparam int POS_RX_GPIO    = 5;
  localparam int POS_GIO1_IN    = 0;
  localparam int POS_GIO1_OUT   = 1;
  localparam int POS_GIO1_OE    = 2;
  localparam int POS_GIO2_OUT   = 3;

  // ---------------------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------------------
  localparam logic [7:0] WIDTH_LIMIT_RESET = 8'hFF;
  localparam logic [7:0] WIDTH_LIMIT_OFF   = 8'hFF;
  localparam logic [7:0] INTERVAL_RESET    = 8'h00;
  localparam logic [3:0] PENDING_MAX       = 4'hF;

  typedef enum logic [1:0] {
    OPPO_TX_UART     = 2'h0,
    OPPO_TX_GIO_TWO  = 2'h1,
    OPPO_TX_REAL     = 2'h2,
    OPPO_TX_REACTIVE = 2'h3
  } oppo_tx_src_t;

endpackage

// ==== include/oppo_shaper_if.sv ====
// Control and status signals between the port top and one pulse channel shaper.
// Assumes both ends run on the same clock.
interface oppo_shaper_if;
  logic       bypass;      // Pacing off: pulses follow the source directly.
  logic       unitStrobe;  // One cycle at the end of each interval unit.
  logic [7:0] widthLimit;  // Limit code; maximum width is twice it plus one units.
  logic       source;      // Pulse request level from the compute engine.
  logic       active;      // Shaped pulse, active high.
  logic [3:0] pending;     // Pulses waiting in the pacing queue.

  modport ctrl   (output bypass, output unitStrobe, output widthLimit, output source,
                  input active, input pending);
  modport shaper (input bypass, input unitStrobe, input widthLimit, input source,
                  output active, output pending);
endinterface

// ==== rtl/oppo_pulse_shaper.sv ====
// One energy pulse channel: width limiting in bypass mode, paced queue otherwise.
// Assumes the strobe and configuration come from logic on the same clock.
module oppo_pulse_shaper
  import oppo_pkg::*;
(
  // Clock and reset.
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Channel signals.
  oppo_shaper_if.shaper ch
);

  typedef struct packed {
    logic       srcPrev;
    logic       active;
    logic       limited;
    logic [8:0] widthCnt;
    logic [3:0] pending;
  } oppo_shaper_t;

  oppo_shaper_t s_r;
  oppo_shaper_t s_nxt;
  logic         rise;
  logic         limitOn;
  logic [8:0]   limitUnits;
  logic [8:0]   cntInc;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // A source held past the limit is cut off and not resumed until it drops.
  always_comb
  begin
    s_nxt       = s_r;
    rise        = ch.source & ~s_r.srcPrev;
    limitOn     = ch.widthLimit != WIDTH_LIMIT_OFF; // R10
    limitUnits  = {ch.widthLimit, 1'b1}; // R8
    cntInc      = s_r.widthCnt + {8'h00, ch.unitStrobe};
    s_nxt.srcPrev = ch.source;
    if (ch.bypass) // R12
    begin
      s_nxt.pending = 4'h0;
      if (!ch.source)
      begin
        s_nxt.active   = 1'b0;
        s_nxt.limited  = 1'b0;
        s_nxt.widthCnt = 9'h000;
      end
      else if (!s_r.limited)
      begin
        s_nxt.active   = 1'b1;
        s_nxt.widthCnt = cntInc; // R9
        if (limitOn && cntInc >= limitUnits)
        begin
          s_nxt.active  = 1'b0; // R14
          s_nxt.limited = 1'b1;
        end
      end
    end
    else
    begin
      // Each queued pulse lasts one unit and is followed by at least one unit low.
      s_nxt.limited  = 1'b0;
      s_nxt.widthCnt = 9'h000;
      if (rise && s_r.pending != PENDING_MAX)
        s_nxt.pending = s_r.pending + 4'h1;
      if (ch.unitStrobe)
      begin
        if (s_r.active)
          s_nxt.active = 1'b0;
        else if (s_nxt.pending != 4'h0)
        begin
          s_nxt.active  = 1'b1;
          s_nxt.pending = s_nxt.pending - 4'h1;
        end
      end
    end
    if (!rst_n)
      s_nxt = '0;
  end

  // State register.
  always_ff @(posedge clk)
    s_r <= s_nxt;

  assign ch.active  = s_r.active;
  assign ch.pending = s_r.pending;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  width_bound_a: assert property (ch.bypass && ch.widthLimit != WIDTH_LIMIT_OFF && s_r.active // R8
    |-> s_r.widthCnt < {ch.widthLimit, 1'b1})
    else $error("Pulse ran past its width limit.");
  limit_off_a: assert property (ch.bypass && ch.widthLimit == WIDTH_LIMIT_OFF && ch.source // R10
    && s_r.active |=> s_r.active)
    else $error("Unlimited pulse was cut short.");
  cut_hold_a: assert property (ch.bypass && s_r.limited && ch.source |=> !s_r.active) // R14
    else $error("Limited pulse restarted while source held.");
  bypass_now_a: assert property (ch.bypass && $rose(ch.source) |=> s_r.active) // R12
    else $error("Bypassed pulse not output at once.");

endmodule

// ==== rtl/oppo_top.sv ====
// Optical port pin routing, carrier modulation and energy pulse output shaping.
// Assumes a classic Wishbone master, a UART and compute engine on the same clock,
// and an outside resolver that builds the receive pin wire from its enable.
//
// Overview of operation
// R1 - Duty select gives carrier low fraction.
// R2 - Receive pin feeds UART unless GPIO selected.
// R3 - Receive invert flips only UART input.
// R4 - GPIO read of receive pin ignores invert.
// R5 - Transmit source: UART, GPIO two, pulses.
// R6 - Transmit invert applied before carrier modulation.
// R7 - Carrier replaces zeros; ones pass through.
// R8 - Pulse width capped at twice limit plus one.
// R9 - Unit is interval, else one sample period.
// R10 - Limit value 255 disables width cap.
// R11 - Software sets interval 81 when pacing.
// R12 - Zero interval bypasses pacing queue entirely.
// R13 - Pulses active low unless invert set.
// R14 - Over-limit pulse ends, remainder is dropped.
//
// The Wishbone interface to the registers is this design's own decision.
module oppo_top
  import oppo_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYCLES,
  parameter int TICK_CYC   = TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone register slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // UART and compute engine side.
  input  wire logic        uartTx,
  output logic             uartRx,
  input  wire logic        realEnergyPulseReq,
  input  wire logic        reactiveEnergyPulseReq,
  // Pins.
  input  wire logic        opticalReceivePinIn,
  output logic             opticalReceivePinOut,
  output logic             opticalReceivePinOe,
  output logic             opticalTransmitPin,
  output logic             realEnergyPulse,
  output logic             reactiveEnergyPulse
);

  typedef struct packed {
    logic               pulseInv;
    logic [1:0]         txSrc;
    logic [1:0]         dutySel;
    logic               txInv;
    logic               txMod;
    logic               rxInv;
    logic               rxGpio;
    logic [7:0]         widthLimit;
    logic [7:0]         interval;
    logic               gioOneOut;
    logic               gioOneOe;
    logic               gioTwoOut;
    logic               rxMeta;
    logic               rxSync;
    logic               uartRx;
    logic               txPin;
    logic [1:0]         pulseLvl;
    logic [3:0]         carrierCnt;
    logic [STEP_W-1:0]  stepCnt;
    logic [TIMER_W-1:0] sampleCnt;
    logic [TIMER_W-1:0] tickCnt;
    logic [7:0]         intervalCnt;
    logic               ack;
    logic [7:0]         rdData;
  } oppo_top_t;

  oppo_top_t   s_r;
  oppo_top_t   s_nxt;
  logic        access;
  logic        doWrite;
  logic [13:0] regIdx;
  logic [7:0]  wrByte;
  logic [7:0]  rdMux;
  logic        carrierStep;
  logic        carrierLow;
  logic        sampleStrobe;
  logic        tickStrobe;
  logic        intervalStrobe;
  logic        unitStrobe;
  logic        txSel;
  logic        txInverted;
  logic [1:0]  chActive;
  logic [1:0]  chReq;

  // ---------------------------------------------------------------------------
  // Pulse channels
  // ---------------------------------------------------------------------------
  assign chReq = {reactiveEnergyPulseReq, realEnergyPulseReq};

  // Both channels share the unit strobe so their paced pulses stay aligned.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gChan
      oppo_shaper_if chIf ();
      assign chIf.bypass     = s_r.interval == 8'h00;
      assign chIf.unitStrobe = unitStrobe;
      assign chIf.widthLimit = s_r.widthLimit;
      assign chIf.source     = chReq[g];
      assign chActive[g]     = chIf.active;
      oppo_pulse_shaper uShaper (
        .clk   (clk),
        .rst_n (rst_n),
        .ch    (chIf.shaper)
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Timebases
  // ---------------------------------------------------------------------------
  // The interval unit falls back to one sample period when pacing is off.
  assign sampleStrobe   = s_r.sampleCnt == TIMER_W'(SAMPLE_CYC - 1);
  assign tickStrobe     = s_r.tickCnt == TIMER_W'(TICK_CYC - 1);
  assign intervalStrobe = tickStrobe && ({1'b0, s_r.intervalCnt} + 9'h001 >= {1'b0, s_r.interval});
  assign unitStrobe     = (s_r.interval == 8'h00) ? sampleStrobe : intervalStrobe; // R9
  assign carrierStep    = s_r.stepCnt == STEP_W'(CARRIER_STEP_CYCLES - 1);
  // Low while the step count is below sixteen shifted right by duty plus one.
  assign carrierLow     = {1'b0, s_r.carrierCnt} < (CARRIER_HALF >> s_r.dutySel); // R1

  // ---------------------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------------------
  // Source is chosen first, inverted next, and only then modulated.
  always_comb
  begin
    case (oppo_tx_src_t'(s_r.txSrc)) // R5
      OPPO_TX_UART:     txSel = uartTx;
      OPPO_TX_GIO_TWO:  txSel = s_r.gioTwoOut;
      OPPO_TX_REAL:     txSel = s_r.pulseLvl[0];
      OPPO_TX_REACTIVE: txSel = s_r.pulseLvl[1];
      default:          txSel = uartTx;
    endcase
    txInverted = txSel ^ s_r.txInv; // R6
  end

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  assign access  = wb_cyc_i & wb_stb_i;
  assign regIdx  = wb_adr_i[15:2];
  assign wrByte  = wb_dat_i[7:0];
  // Writes land on the edge where the master sees ack, so a held request counts once.
  assign doWrite = access & wb_we_i & s_r.ack & wb_sel_i[0];

  // Read multiplexer; unmapped indices read as zero.
  always_comb
  begin
    rdMux = 8'h00;
    case (regIdx)
      IDX_PULSE_CFG:  rdMux[POS_PULSE_INV] = s_r.pulseInv;
      IDX_TX_CFG:
      begin
        rdMux[POS_TX_SRC+:2] = s_r.txSrc;
        rdMux[POS_DUTY+:2]   = s_r.dutySel;
      end
      IDX_PORT_CFG:
      begin
        rdMux[POS_TX_INV]  = s_r.txInv;
        rdMux[POS_TX_MOD]  = s_r.txMod;
        rdMux[POS_RX_INV]  = s_r.rxInv;
        rdMux[POS_RX_GPIO] = s_r.rxGpio;
      end
      IDX_WIDTH_LIM:  rdMux = s_r.widthLimit;
      IDX_INTERVAL:   rdMux = s_r.interval;
      IDX_GENERAL_IO:
      begin
        rdMux[POS_GIO1_IN]  = s_r.rxSync; // R4
        rdMux[POS_GIO1_OUT] = s_r.gioOneOut;
        rdMux[POS_GIO1_OE]  = s_r.gioOneOe;
        rdMux[POS_GIO2_OUT] = s_r.gioTwoOut;
      end
      IDX_STATUS:     rdMux = {4'h0, s_r.txPin, s_r.uartRx, chActive};
      default:        rdMux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    // Bus handshake: one wait cycle, then ack for exactly one cycle.
    s_nxt.ack = access & ~s_r.ack;
    if (access & ~s_r.ack)
      s_nxt.rdData = rdMux;
    if (doWrite)
    begin
      case (regIdx)
        IDX_PULSE_CFG:  s_nxt.pulseInv = wrByte[POS_PULSE_INV];
        IDX_TX_CFG:
        begin
          s_nxt.txSrc   = wrByte[POS_TX_SRC+:2];
          s_nxt.dutySel = wrByte[POS_DUTY+:2];
        end
        IDX_PORT_CFG:
        begin
          s_nxt.txInv  = wrByte[POS_TX_INV];
          s_nxt.txMod  = wrByte[POS_TX_MOD];
          s_nxt.rxInv  = wrByte[POS_RX_INV];
          s_nxt.rxGpio = wrByte[POS_RX_GPIO];
        end
        IDX_WIDTH_LIM:  s_nxt.widthLimit = wrByte;
        IDX_INTERVAL:   s_nxt.interval   = wrByte; // R11
        IDX_GENERAL_IO:
        begin
          s_nxt.gioOneOut = wrByte[POS_GIO1_OUT];
          s_nxt.gioOneOe  = wrByte[POS_GIO1_OE];
          s_nxt.gioTwoOut = wrByte[POS_GIO2_OUT];
        end
        default:        ; // Unmapped writes are dropped; the ack stays a single cycle.
      endcase
    end
    // Two-stage synchroniser for the receive pin.
    s_nxt.rxMeta = opticalReceivePinIn;
    s_nxt.rxSync = s_r.rxMeta;
    // The UART idles high while the pin is given over to general I/O.
    s_nxt.uartRx = s_r.rxGpio ? 1'b1 : (s_r.rxSync ^ s_r.rxInv); // R2 R3
    // Active-high pulses become active-low pin levels unless inverted.
    s_nxt.pulseLvl = s_r.pulseInv ? chActive : ~chActive; // R13
    // A one passes unchanged; a zero becomes the carrier when modulating.
    s_nxt.txPin = (s_r.txMod && !txInverted) ? ~carrierLow : txInverted; // R7
    // Free-running timers.
    s_nxt.stepCnt   = carrierStep ? '0 : s_r.stepCnt + STEP_W'(1);
    s_nxt.sampleCnt = sampleStrobe ? '0 : s_r.sampleCnt + TIMER_W'(1);
    s_nxt.tickCnt   = tickStrobe ? '0 : s_r.tickCnt + TIMER_W'(1);
    if (carrierStep)
      s_nxt.carrierCnt = s_r.carrierCnt + 4'h1;
    if (intervalStrobe || s_r.interval == 8'h00)
      s_nxt.intervalCnt = 8'h00;
    else if (tickStrobe)
      s_nxt.intervalCnt = s_r.intervalCnt + 8'h01;
    if (!rst_n)
    begin
      s_nxt            = '0;
      s_nxt.widthLimit = WIDTH_LIMIT_RESET;
      s_nxt.interval   = INTERVAL_RESET;
      s_nxt.uartRx     = 1'b1;
      // The synchroniser starts at the idle line level, so the UART sees no false start bit.
      s_nxt.rxMeta     = 1'b1;
      s_nxt.rxSync     = 1'b1;
      s_nxt.txPin      = 1'b1;
      s_nxt.pulseLvl   = 2'b11;
    end
  end

  // State register.
  always_ff @(posedge clk)
    s_r <= s_nxt;

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign wb_ack_o             = s_r.ack;
  assign wb_dat_o             = {24'h000000, s_r.rdData};
  assign uartRx               = s_r.uartRx;
  assign opticalTransmitPin   = s_r.txPin;
  assign realEnergyPulse      = s_r.pulseLvl[0];
  assign reactiveEnergyPulse  = s_r.pulseLvl[1];
  // The receive pin drives only as general I/O, never while it feeds the UART.
  assign opticalReceivePinOut = s_r.gioOneOut;
  assign opticalReceivePinOe  = s_r.rxGpio & s_r.gioOneOe; // R2

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence lowStep_s;
    carrierStep && s_r.carrierCnt == CARRIER_LAST;
  endsequence
  sequence eighthEnd_s;
    carrierStep && s_r.carrierCnt == 4'h1 && s_r.dutySel == 2'h2;
  endsequence

  carrier_start_a: assert property (lowStep_s |=> carrierLow) // R1
    else $error("Carrier period did not start low.");
  carrier_eighth_a: assert property (eighthEnd_s ##1 $stable(s_r.dutySel) |-> !carrierLow) // R1
    else $error("Carrier low fraction wrong at one eighth.");
  rx_gpio_a: assert property (s_r.rxGpio |=> s_r.uartRx) // R2
    else $error("UART saw receive pin while in general I/O use.");
  rx_invert_a: assert property (!s_r.rxGpio && $stable(s_r.rxInv) |=> // R3
    s_r.uartRx == ($past(s_r.rxSync) ^ $past(s_r.rxInv)))
    else $error("UART receive inversion wrong.");
  rx_gio_read_a: assert property (s_r.rxInv && !s_r.ack && access && regIdx == IDX_GENERAL_IO // R4
    |=> s_r.rdData[POS_GIO1_IN] == $past(s_r.rxSync))
    else $error("General I/O read was inverted.");
  tx_route_a: assert property (!s_r.txMod && !s_r.txInv && s_r.txSrc == 2'h2 // R5
    |=> s_r.txPin == $past(s_r.pulseLvl[0]))
    else $error("Transmit pin not routed from real pulse.");
  tx_invert_a: assert property (!s_r.txMod && s_r.txInv && s_r.txSrc == 2'h0 // R6
    |=> s_r.txPin == !$past(uartTx))
    else $error("Transmit inversion wrong.");
  tx_carrier_a: assert property (s_r.txMod && !txInverted |=> s_r.txPin == !$past(carrierLow)) // R7
    else $error("Zero not replaced by carrier.");
  tx_pass_one_a: assert property (s_r.txMod && txInverted |=> s_r.txPin) // R7
    else $error("One was modulated.");
  unit_sample_a: assert property (s_r.interval == 8'h00 |-> unitStrobe == sampleStrobe) // R9
    else $error("Unit not one sample period with zero interval.");
  pulse_pol_a: assert property ($stable(s_r.pulseInv) ##1 $stable(s_r.pulseInv) |-> // R13
    s_r.pulseLvl == (s_r.pulseInv ? $past(chActive) : ~$past(chActive)))
    else $error("Pulse pin polarity wrong.");
  bus_ack_a: assert property (access && !s_r.ack |=> s_r.ack ##1 !s_r.ack)
    else $error("Bus ack not a single cycle after one wait.");

endmodule

// ==== bench/oppo_ir_model.sv ====
// Far-side optical transceiver: lights the receive pin and counts dark transmit cycles.
// Assumes the bench clock; the transmit pin is high while the emitter is on.
module oppo_ir_model
(
  // Clock.
  input  wire logic        clk,
  // Optical side.
  input  wire logic        txPin,
  output logic             rxLevel,
  // Bench control.
  input  wire logic        light,
  input  wire logic        clear,
  output logic      [15:0] lowCount
);
  timeunit 1ns;
  timeprecision 1ps;

  // The comparator output follows the light level.
  assign rxLevel = light;

  // Counting dark cycles measures the carrier duty over a whole period.
  always @(posedge clk)
    if (clear)
      lowCount <= 16'h0000;
    else if (!txPin)
      lowCount <= lowCount + 16'h0001;
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the optical port and pulse output block.
// Assumes short timebase parameters so one sample unit is 64 clocks.
module testbench;
  import oppo_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, ack, uartRx, rxIn, rxOut, rxOe, txPin, realPin, reactPin, rxLevel;
  logic        rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, uartTx = 1'b1;
  logic        realReq = 1'b0, reactReq = 1'b0, light = 1'b1, clr = 1'b1;
  logic [15:0] adr = 16'h0000, lowCnt;
  logic [31:0] wdat = 32'h0, rdat, q;
  int          err_count = 0, comparisons = 0, waitCnt = 0;

  // Receive pin wire: the design wins while it drives, else the transceiver.
  assign rxIn = rxOe ? rxOut : rxLevel;

  // Clock at 250 MHz.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  oppo_top #(.SAMPLE_CYC(64), .TICK_CYC(4)) oppo_top_i (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .uartTx(uartTx), .uartRx(uartRx), .realEnergyPulseReq(realReq),
    .reactiveEnergyPulseReq(reactReq), .opticalReceivePinIn(rxIn),
    .opticalReceivePinOut(rxOut), .opticalReceivePinOe(rxOe),
    .opticalTransmitPin(txPin), .realEnergyPulse(realPin), .reactiveEnergyPulse(reactPin));

  oppo_ir_model oppo_ir_model_i (.clk(clk), .txPin(txPin), .rxLevel(rxLevel),
    .light(light), .clear(clr), .lowCount(lowCnt));

  // Verdict and end of run.
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  // One classic cycle; ack is sampled at the rising edge, where data is taken and the request drops.
  task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      err_count++;
      conclude();
    end
    else
    begin
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask

  // Waits whole cycles, then settles mid-cycle for sampling.
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Dark cycles over one full carrier period of sixteen steps.
  task automatic dark(input string what, input logic [31:0] exp);
    wt(8);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    repeat (16 * CARRIER_STEP_CYCLES) @(posedge clk);
    @(negedge clk);
    check(what, exp, {16'h0, lowCnt});
  endtask

  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wt(3);
    bus(0, IDX_WIDTH_LIM, 8'h00); check("limit reset", 32'hFF, q);
    bus(0, IDX_INTERVAL, 8'h00); check("interval reset", 32'h0, q);
    bus(1, 14'h2100, 8'h5A); bus(0, 14'h2100, 8'h00); check("unmapped", 32'h0, q);
    wt(0); check("tx idle", 1, txPin);
    check("real idle", 1, realPin);
    // Receive path to the UART and as general input.
    @(posedge clk) light <= 1'b0;
    wt(5); check("uart rx", 0, uartRx);
    bus(1, IDX_PORT_CFG, 8'h10); wt(3); check("rx inverted", 1, uartRx);
    bus(1, IDX_PORT_CFG, 8'h20); wt(3); check("rx gpio uart", 1, uartRx);
    bus(1, IDX_PORT_CFG, 8'h30); bus(0, IDX_GENERAL_IO, 8'h00); check("gpio in low", 0, q[0]);
    @(posedge clk) light <= 1'b1;
    wt(5); bus(0, IDX_GENERAL_IO, 8'h00); check("gpio in high", 1, q[0]);
    // General I/O one drives the receive pin against a dark transceiver.
    bus(1, IDX_GENERAL_IO, 8'h06); @(posedge clk) light <= 1'b0;
    wt(5); check("gio one oe", 1, rxOe);
    bus(0, IDX_GENERAL_IO, 8'h00); check("gio one drive", 32'h07, q);
    // Transmit source selection and inversion.
    bus(1, IDX_PORT_CFG, 8'h00);
    @(posedge clk) uartTx <= 1'b0;
    wt(3); check("tx uart", 0, txPin);
    bus(1, IDX_PORT_CFG, 8'h01); wt(3); check("tx inverted", 1, txPin);
    bus(1, IDX_PORT_CFG, 8'h00); bus(1, IDX_TX_CFG, 8'h40);
    bus(1, IDX_GENERAL_IO, 8'h08); wt(3); check("tx gpio two", 1, txPin);
    bus(1, IDX_GENERAL_IO, 8'h00); wt(3); check("tx gpio two", 0, txPin);
    bus(1, IDX_TX_CFG, 8'h80); wt(3); check("tx real", 1, txPin);
    bus(1, IDX_PULSE_CFG, 8'h40); wt(3); check("tx real inv", 0, txPin);
    check("real inv idle", 0, realPin);
    // Inverted reactive pulse with no width limit.
    bus(1, IDX_TX_CFG, 8'hC0);
    @(posedge clk) reactReq <= 1'b1;
    wt(4); check("react active", 1, reactPin);
    check("tx reactive", 1, txPin);
    wt(33000); check("no limit", 1, reactPin);
    @(posedge clk) reactReq <= 1'b0;
    wt(4); check("react idle", 0, reactPin);
    // Width limit of three units on the real pulse.
    bus(1, IDX_PULSE_CFG, 8'h00); bus(1, IDX_WIDTH_LIM, 8'h01);
    @(posedge clk) realReq <= 1'b1;
    wt(120); check("real within", 0, realPin);
    wt(80); check("real cut", 1, realPin);
    @(posedge clk) realReq <= 1'b0;
    wt(4); check("real idle", 1, realPin);
    // One paced pulse: low for one unit of 81 ticks, then idle again.
    bus(1, IDX_INTERVAL, 8'h51);
    @(posedge clk) realReq <= 1'b1;
    @(posedge clk) realReq <= 1'b0;
    for (waitCnt = 0; waitCnt < 400 && realPin !== 1'b0; waitCnt++)
      @(negedge clk);
    check("paced start", 0, realPin);
    wt(160); check("paced held", 0, realPin);
    wt(200); check("paced end", 1, realPin);
    bus(1, IDX_INTERVAL, 8'h00);
    // Carrier duty on zeros, ones pass, invert ahead of modulation.
    bus(1, IDX_TX_CFG, 8'h00); bus(1, IDX_PORT_CFG, 8'h02);
    for (int d = 0; d < 4; d++)
    begin
      bus(1, IDX_TX_CFG, d[7:0]);
      dark("carrier low", CARRIER_STEP_CYCLES * (8 >> d));
    end
    @(posedge clk) uartTx <= 1'b1;
    dark("ones pass", 32'h0);
    bus(1, IDX_PORT_CFG, 8'h03);
    dark("inverted carrier", CARRIER_STEP_CYCLES);
    conclude();
  end
endmodule
